// ===== hw/gpsc_pkg.sv
// Package with offsets, field layout and constants of the pin sequencing bank.
package gpsc_pkg;
	localparam int NUM_PINS = 4;
	localparam logic [7:0] OFS_PIN0 = 8'ha8;
	localparam logic [7:0] OFS_PIN1 = 8'ha9;
	localparam logic [7:0] OFS_PIN2 = 8'haa;
	localparam logic [7:0] OFS_PIN7 = 8'hab;
	localparam logic [7:0] OFS_SEQ_STATE = 8'hb0;
	localparam int SRC_HI = 7;
	localparam int SRC_LO = 6;
	localparam int UP_HI = 5;
	localparam int UP_LO = 3;
	localparam int DN_HI = 2;
	localparam int DN_LO = 0;
	localparam logic [1:0] SRC_SEQ0 = 2'h0;
	localparam logic [1:0] SRC_SEQ1_A = 2'h1;
	localparam logic [1:0] SRC_SEQ1_B = 2'h2;
	localparam logic [1:0] SRC_NONE = 2'h3;
	localparam logic [7:0] CFG_RESET = 8'hc0;
	localparam logic [31:0] RDATA_RESET = 32'h0;
endpackage : gpsc_pkg

// ===== hw/gpsc_pin_slot.sv
// One pin's sequence membership decode and active state tracking.
`timescale 1ns/10ps
`default_nettype none
module gpsc_pin_slot (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Stored configuration of this pin
	input wire logic [7:0] cfg,
	// Sequencer position for both sequences
	input wire logic seq0_up_strobe,
	input wire logic seq0_dn_strobe,
	input wire logic [2:0] seq0_slot,
	input wire logic seq1_up_strobe,
	input wire logic seq1_dn_strobe,
	input wire logic [2:0] seq1_slot,
	// Pin drive state
	output logic active_ff
);
	logic [1:0] src;
	logic [2:0] up_slot;
	logic [2:0] dn_slot;
	logic in_seq0;
	logic in_seq1;
	logic hit_up;
	logic hit_dn;
	logic nxt_active;

	// Field split and membership decode.
	assign src = cfg[gpsc_pkg::SRC_HI:gpsc_pkg::SRC_LO];
	assign up_slot = cfg[gpsc_pkg::UP_HI:gpsc_pkg::UP_LO];
	assign dn_slot = cfg[gpsc_pkg::DN_HI:gpsc_pkg::DN_LO];
	assign in_seq0 = (src == gpsc_pkg::SRC_SEQ0);
	// Both codes map to sequence one; the unused code is left out entirely.
	assign in_seq1 = (src == gpsc_pkg::SRC_SEQ1_A) ||
		(src == gpsc_pkg::SRC_SEQ1_B);
	assign hit_up = (in_seq0 && seq0_up_strobe && seq0_slot == up_slot) ||
		(in_seq1 && seq1_up_strobe && seq1_slot == up_slot);
	assign hit_dn = (in_seq0 && seq0_dn_strobe && seq0_slot == dn_slot) ||
		(in_seq1 && seq1_dn_strobe && seq1_slot == dn_slot);
	// Release wins if both strobes meet, so such a collision never leaves the pin on.
	assign nxt_active = hit_dn ? 1'b0 : (hit_up ? 1'b1 : active_ff);

	// Active state register.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			active_ff <= 1'b0;
		end else begin
			active_ff <= nxt_active;
		end
	end
endmodule : gpsc_pin_slot
`default_nettype wire

// ===== hw/gpsc_top.sv
// Pin power sequencing slot configuration bank with Avalon-MM access.
// Operation
// - Source code 0 puts the pin on sequence zero, codes 1 and 2 on sequence one.
// - Source code 3 keeps the pin out of both sequences.
// - Bits 5:3 give the power-up slot as a plain binary number 0 to 7.
// - Bits 2:0 give the power-down slot as a plain binary number 0 to 7.
// - All three fields are writable and read back as stored.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module gpsc_top #(
	parameter int NUM_PINS = gpsc_pkg::NUM_PINS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// Sequencer position from the timing engine
	input wire logic seq0_up_strobe,
	input wire logic seq0_dn_strobe,
	input wire logic [2:0] seq0_slot,
	input wire logic seq1_up_strobe,
	input wire logic seq1_dn_strobe,
	input wire logic [2:0] seq1_slot,
	// Pin resource drive states, bit order pin0, pin1, pin2, pin7
	output logic [NUM_PINS-1:0] pin_active
);
	logic [7:0] cfg_ff [NUM_PINS];
	logic [NUM_PINS-1:0] active;
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [1:0] resp_ff;
	logic [7:0] offsets [NUM_PINS];
	logic [NUM_PINS-1:0] sel;
	logic sel_state;
	logic req;
	logic hit;
	logic [7:0] rd_cfg;
	logic [31:0] nxt_rdata;

	assign offsets[0] = gpsc_pkg::OFS_PIN0;
	assign offsets[1] = gpsc_pkg::OFS_PIN1;
	assign offsets[2] = gpsc_pkg::OFS_PIN2;
	assign offsets[3] = gpsc_pkg::OFS_PIN7;

	// Request is answered one cycle after it appears; waitrequest holds
	// it until then, so every access costs exactly two cycles.
	assign req = (avs_read || avs_write) && !ack_ff;
	assign sel_state = (avs_address == gpsc_pkg::OFS_SEQ_STATE);
	assign hit = (|sel) || sel_state;

	// Per-pin decode, storage and sequencing slice.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			assign sel[gi] = (avs_address == offsets[gi]);
			// Only lane 0 carries the byte; other lanes are ignored.
			// The store waits for the acknowledge cycle, so a write lands
			// at the very edge at which the master sees waitrequest low.
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					cfg_ff[gi] <= gpsc_pkg::CFG_RESET;
				end else if (ack_ff && avs_write && sel[gi] && avs_byteenable[0]) begin
					cfg_ff[gi] <= avs_writedata[7:0];
				end
			end
			gpsc_pin_slot u_slot (
				.sys_clk(sys_clk),
				.nrst(nrst),
				.cfg(cfg_ff[gi]),
				.seq0_up_strobe(seq0_up_strobe),
				.seq0_dn_strobe(seq0_dn_strobe),
				.seq0_slot(seq0_slot),
				.seq1_up_strobe(seq1_up_strobe),
				.seq1_dn_strobe(seq1_dn_strobe),
				.seq1_slot(seq1_slot),
				.active_ff(active[gi])
			);
		end
	endgenerate

	// Read mux; a pin register reads back its stored byte.
	always_comb begin
		rd_cfg = 8'h00;
		for (int i = 0; i < NUM_PINS; i++) begin
			if (sel[i]) begin
				rd_cfg = cfg_ff[i];
			end
		end
	end
	assign nxt_rdata = sel_state ? {{(32-NUM_PINS){1'b0}}, active} :
		{24'h000000, rd_cfg};

	// Bus answer registers.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ack_ff <= 1'b0;
			rdata_ff <= gpsc_pkg::RDATA_RESET;
			resp_ff <= 2'h0;
		end else begin
			ack_ff <= req;
			if (req) begin
				rdata_ff <= (avs_read && hit) ? nxt_rdata : gpsc_pkg::RDATA_RESET;
				// Unmapped addresses answer with the decode error code.
				resp_ff <= hit ? 2'h0 : 2'h3;
			end
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_response = resp_ff;
	// Waitrequest is the registered complement of the request, so it always equals the inverse of the acknowledge.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !req;
		end
	end
	assign pin_active = active;
endmodule : gpsc_top
`default_nettype wire

// ===== testbench/gpsc_props.sv
// Checker of the pin sequencing bank at its top ports.
`timescale 1ns/10ps
`default_nettype none
module gpsc_props #(parameter int NUM_PINS = 4) (
	// Clock, reset and bus
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Sequencer and pins
	input wire logic seq0_up_strobe,
	input wire logic seq0_dn_strobe,
	input wire logic [2:0] seq0_slot,
	input wire logic seq1_up_strobe,
	input wire logic seq1_dn_strobe,
	input wire logic [2:0] seq1_slot,
	input wire logic [NUM_PINS-1:0] pin_active
);
	logic [7:0] cfg_ff;
	wire logic wr0 = avs_write && !avs_waitrequest && avs_address == 8'ha8;
	wire logic [1:0] src = cfg_ff[7:6];
	// Pin 0 mirror, taken at the acknowledged write only.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) cfg_ff <= gpsc_pkg::CFG_RESET;
		else if (wr0) cfg_ff <= avs_writedata[7:0];
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	ack_once_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("late ack");
	read_back_a: assert property (avs_read && !avs_waitrequest
		&& avs_address == 8'ha8 |-> avs_readdata == {24'h0, cfg_ff})
		else $error("bad readback");
	up_zero_a: assert property (seq0_up_strobe && src == 2'h0
		&& seq0_slot == cfg_ff[5:3]
		&& !(seq0_dn_strobe && seq0_slot == cfg_ff[2:0])
		|=> pin_active[0]) else $error("no up");
	up_one_a: assert property (seq1_up_strobe && src inside {2'h1, 2'h2}
		&& seq1_slot == cfg_ff[5:3]
		&& !(seq1_dn_strobe && seq1_slot == cfg_ff[2:0])
		|=> pin_active[0]) else $error("no up");
	down_one_a: assert property (seq1_dn_strobe && src inside {2'h1, 2'h2}
		&& seq1_slot == cfg_ff[2:0] |=> !pin_active[0]) else $error("no down");
	down_zero_a: assert property (seq0_dn_strobe && src == 2'h0
		&& seq0_slot == cfg_ff[2:0] |=> !pin_active[0]) else $error("no down");
	no_seq_a: assert property (src == 2'h3 && !pin_active[0]
		|=> !pin_active[0]) else $error("pin moved");
endmodule : gpsc_props
bind gpsc_top gpsc_props #(.NUM_PINS(NUM_PINS)) i_props (.sys_clk, .nrst,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
	.avs_waitrequest, .seq0_up_strobe, .seq0_dn_strobe, .seq0_slot,
	.seq1_up_strobe, .seq1_dn_strobe, .seq1_slot, .pin_active);
`default_nettype wire

// ===== testbench/gpsc_top_tb.sv
// Self-checking bench of the pin sequencing bank.
`timescale 1ns/10ps
`default_nettype none
module gpsc_top_tb;
	logic sys_clk = 0, nrst = 0, avs_read = 0, avs_write = 0;
	logic [7:0] avs_address = 0, d;
	logic [31:0] avs_writedata = 0, avs_readdata;
	logic seq0_up_strobe = 0, seq0_dn_strobe = 0;
	logic seq1_up_strobe = 0, seq1_dn_strobe = 0;
	logic [2:0] seq0_slot = 0, seq1_slot = 0, up, dn;
	logic avs_waitrequest;
	logic [1:0] avs_response;
	logic [3:0] pin_active;
	logic [3:0] be = 4'hf;
	logic [33:0] rd;
	int err_count = 0, tests_run = 0, act;
	// Half period of 20 ns gives 25 MHz.
	always #20 sys_clk = ~sys_clk;
	gpsc_top i_dut (.sys_clk, .nrst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(be), .avs_readdata,
		.avs_waitrequest, .avs_response, .seq0_up_strobe, .seq0_dn_strobe,
		.seq0_slot, .seq1_up_strobe, .seq1_dn_strobe, .seq1_slot, .pin_active);
	task chk(input logic [33:0] g, input logic [33:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Holds the request until waitrequest is seen low, the slave's pace.
	task bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		{avs_read, avs_write, avs_address} <= {!w, w, a};
		avs_writedata <= {24'h0, v};
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = {avs_response, avs_readdata};
		{avs_read, avs_write} <= 2'h0;
	endtask : bus
	// One strobe of sequence q; one model bit is checked against all four pins.
	task stb(input int q, input logic u, input int s);
		@(posedge sys_clk);
		{seq0_up_strobe, seq0_dn_strobe, seq1_up_strobe, seq1_dn_strobe}
			<= q ? {2'h0, u, !u} : {u, !u, 2'h0};
		{seq0_slot, seq1_slot} <= u ? {up, up} : {dn, dn};
		@(posedge sys_clk);
		{seq0_up_strobe, seq0_dn_strobe, seq1_up_strobe, seq1_dn_strobe} <= 0;
		@(posedge sys_clk);
		if (s != 3 && (s == 0) == (q == 0)) act = u;
		chk({30'h0, pin_active}, {30'h0, {4{act[0]}}});
		bus(0, 8'hb0, 8'h0);
		chk(rd, {30'h0, {4{act[0]}}});
	endtask : stb
	task final_report;
		$display("compares %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report
	// Main sequence: registers, unmapped read, then every source code.
	initial begin
		void'($urandom(6087));
		repeat (8) @(posedge sys_clk);
		nrst <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			bus(0, 8'ha8 + 8'(i), 8'h0);
			chk(rd, {26'h0, gpsc_pkg::CFG_RESET});
			bus(1, 8'ha8 + 8'(i), d);
			bus(0, 8'ha8 + 8'(i), 8'h0);
			chk(rd, {26'h0, d});
		end
		// A write without lane 0 must leave the byte untouched.
		be <= 4'he;
		bus(1, 8'hab, ~d);
		be <= 4'hf;
		bus(0, 8'hab, 8'h0);
		chk(rd, {26'h0, d});
		bus(0, 8'hb5, 8'h0);
		chk(rd, {2'h3, 32'h0});
		$display("test registers done");
		for (int s = 0; s < 4; s++) begin
			up = 3'($urandom);
			dn = up + 3'h1;
			for (int j = 0; j < 4; j++) bus(1, 8'ha8 + 8'(j), {2'(s), up, dn});
			act = 0;
			for (int k = 0; k < 4; k++) stb(k % 2, k < 2, s);
		end
		$display("test sequencing done");
		final_report;
	end
	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		final_report;
	end
endmodule : gpsc_top_tb
`default_nettype wire
